// [hw/mch_pkg.sv]
// Constants for the remote-terminal mode command 7/8 handler
package mch_pkg;
   // Mode codes handled here
   localparam logic [4:0] MC_OVERRIDE_FLAG = 5'h07;
   localparam logic [4:0] MC_RESET_TERM = 5'h08;
   // Register offsets on the plain register port
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_STATUS_BITS = 8'h01;
   localparam logic [7:0] OFS_DESC_CTRL = 8'h02;
   localparam logic [7:0] OFS_MSG_INFO = 8'h03;
   localparam logic [7:0] OFS_INT_STATUS = 8'h04;
   localparam logic [7:0] OFS_INT_CLEAR = 8'h05;
   localparam logic [7:0] OFS_INT_ENABLE = 8'h06;
   localparam logic [7:0] OFS_SHUTDOWN = 8'h07;
   localparam logic [7:0] OFS_BIT_WORD = 8'h13;
   // Configuration fields
   localparam int CFG_UMC_INV = 0;
   localparam int CFG_SW_RESET = 1;
   // Internal status fields
   localparam int ST_BUSY = 0;
   localparam int ST_ME = 1;
   localparam int ST_BCR = 2;
   // Descriptor control word fields
   localparam int DESC_BUFFER_ACCESSED_FLAG = 0;
   localparam int DESC_BROADCAST_FLAG = 1;
   localparam int DESC_DPB = 2;
   // Message info word fields
   localparam int INFO_BUS_IDENTITY_BIT = 0;
   localparam int INFO_MESSAGE_ERROR_INFO = 1;
   localparam int INFO_ILLEGAL_COMMAND_INFO = 2;
   localparam int INFO_TERMINAL_TO_TERMINAL_INFO = 3;
   localparam int INFO_WORD_COUNT_ERROR_INFO = 4;
   localparam int INFO_GAP_ERROR_INFO = 5;
   localparam logic [5:0] INFO_ERR_MASK = 6'h3E;
   // Interrupt status, clear and enable fields
   localparam int INT_WORD_ACCESS = 0;
   localparam int INT_BROADCAST = 1;
   localparam int INT_ILLEGAL = 2;
   localparam int INT_MSG_ERROR = 3;
   localparam int NUM_INT = 4;
   // Flag-inhibit bit inside the built-in-test word
   localparam int BIT_FLAG_INH = 0;
   localparam logic [15:0] BIT_WORD_RESET = 16'h0000;
   // Reset-terminal sequencing
   typedef enum logic [0:0]
   {
      MCH_IDLE = 1'b0,
      MCH_WAIT_TX = 1'b1
   } mch_state_t;
endpackage

// [hw/mch_handler.sv]
// Mode command 7/8 handler of a remote terminal with its register port
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
//
// Function
// - Invalid or undefined receive form is ignored entirely
// - Receive form, legal: clear ME, status unless broadcast
// - In-form case updates descriptor, clears info errors
// - Illegalized receive form sets ME and illegal bits
// - Flag override with data word: ME, count error
// - Reset terminal with data word: ME, gap error
// - Reset terminal transmit form answers normally
// - After its status, clear ME, busy, BCR
// - Reset terminal zeroes the built-in-test word
// - Reset terminal cancels transmitter shutdown on both buses
// - Reset terminal cancels terminal flag inhibit
// - Configuration registers survive reset terminal command
// - Flag override command clears the flag-inhibit bit
module mch_handler
   import mch_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic cmd_word_ok,
   input wire logic [4:0] cmd_mode_code,
   input wire logic cmd_tr,
   input wire logic cmd_broadcast,
   input wire logic cmd_bus_b,
   input wire logic cmd_illegal,
   input wire logic cmd_data_follows,
   input wire logic status_tx_done,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic status_send,
   output logic msg_write,
   output logic status_me,
   output logic status_bcr,
   output logic status_busy,
   output logic flag_inhibit,
   output logic shutdown_a,
   output logic shutdown_b,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////////
   mch_state_t state, next_state;
   logic umc_inv, next_umc_inv;
   logic [2:0] desc, next_desc;
   logic [5:0] info, next_info;
   logic [NUM_INT-1:0] int_stat, next_int_stat, int_en, next_int_en, int_set;
   logic me, next_me, bcr, next_bcr, busy, next_busy;
   logic [15:0] bit_word, next_bit_word, next_rdata;
   logic [1:0] shut, next_shut;
   logic next_status_send, next_msg_write;
   logic is_mc, ignored, take, rx_form, mc8_tx, mc7_tx, wr_hit;

   // Qualify the command: only the two mode codes owned by this block
   assign is_mc = (cmd_mode_code == MC_OVERRIDE_FLAG) || (cmd_mode_code == MC_RESET_TERM);
   assign ignored = !cmd_word_ok || (!cmd_tr && umc_inv);
   assign take = cmd_valid && is_mc && !ignored;
   assign rx_form = take && !cmd_data_follows && !cmd_tr;
   assign mc8_tx = take && !cmd_data_follows && cmd_tr && cmd_mode_code == MC_RESET_TERM;
   assign mc7_tx = take && !cmd_data_follows && cmd_tr && cmd_mode_code == MC_OVERRIDE_FLAG;
   assign wr_hit = wr && addr == OFS_INT_CLEAR;

   ////////////////////////////////////////////////////////////////////////////////
   // Message handling, status bits, test word, shutdown and register access
   always_comb
   begin
      next_state = state;
      next_umc_inv = umc_inv;
      next_desc = desc;
      next_info = info;
      next_me = me;
      next_bcr = bcr;
      next_busy = busy;
      next_bit_word = bit_word;
      next_shut = shut;
      next_int_en = int_en;
      next_status_send = 1'b0;
      next_msg_write = 1'b0;
      next_rdata = rdata;
      int_set = '0;
      // Host writes come first so that the command below can override them
      if (wr)
      begin
         if (addr == OFS_CONFIG)
         begin
            next_umc_inv = wdata[CFG_UMC_INV];
            if (wdata[CFG_SW_RESET])
            begin
               next_bit_word[BIT_FLAG_INH] = 1'b0; // Self-clearing software reset
            end
         end
         else if (addr == OFS_STATUS_BITS)
         begin
            next_busy = wdata[ST_BUSY];
         end
         else if (addr == OFS_INT_ENABLE)
         begin
            next_int_en = wdata[NUM_INT-1:0];
         end
         else if (addr == OFS_SHUTDOWN)
         begin
            next_shut = shut | wdata[1:0];
         end
         else if (addr == OFS_BIT_WORD)
         begin
            next_bit_word = wdata;
         end
      end
      // Status clear waits for the transmitter so the outgoing word keeps its bits
      if (state == MCH_WAIT_TX && status_tx_done)
      begin
         next_me = 1'b0;
         next_busy = 1'b0;
         next_bcr = 1'b0;
         next_state = MCH_IDLE;
      end
      if (take)
      begin
         next_msg_write = 1'b1;
         next_desc[DESC_DPB] = !desc[DESC_DPB];
         next_info = '0;
         next_info[INFO_BUS_IDENTITY_BIT] = cmd_bus_b;
         int_set[INT_WORD_ACCESS] = 1'b1;
         if (cmd_data_follows)
         begin
            // Data word after a mode code: answer nothing, flag the error
            next_me = 1'b1;
            next_desc[DESC_BUFFER_ACCESSED_FLAG] = 1'b1;
            next_desc[DESC_BROADCAST_FLAG] = 1'b0;
            next_info[INFO_MESSAGE_ERROR_INFO] = 1'b1;
            if (cmd_mode_code == MC_OVERRIDE_FLAG)
            begin
               next_info[INFO_WORD_COUNT_ERROR_INFO] = 1'b1;
            end
            else
            begin
               next_info[INFO_GAP_ERROR_INFO] = 1'b1;
            end
            int_set[INT_MSG_ERROR] = 1'b1;
         end
         else
         begin
            next_me = !cmd_tr && cmd_illegal;
            next_status_send = !cmd_broadcast;
            if (cmd_broadcast)
            begin
               next_bcr = 1'b1;
            end
            next_desc[DESC_BUFFER_ACCESSED_FLAG] = !cmd_tr;
            next_desc[DESC_BROADCAST_FLAG] = cmd_broadcast;
            int_set[INT_BROADCAST] = cmd_broadcast;
            if (!cmd_tr && cmd_illegal)
            begin
               next_info[INFO_MESSAGE_ERROR_INFO] = 1'b1;
               next_info[INFO_ILLEGAL_COMMAND_INFO] = 1'b1;
               int_set[INT_ILLEGAL] = 1'b1;
            end
         end
         if (mc7_tx)
         begin
            next_bit_word[BIT_FLAG_INH] = 1'b0;
         end
         if (mc8_tx)
         begin
            // Configuration fields are deliberately left alone here
            next_bit_word = BIT_WORD_RESET;
            next_shut = 2'b00;
            next_state = cmd_broadcast ? MCH_IDLE : MCH_WAIT_TX;
         end
      end
      // Read data: one cycle after the strobe, unmapped reads give zero
      if (rd)
      begin
         if (addr == OFS_CONFIG)
         begin
            next_rdata = {15'h0000, umc_inv};
         end
         else if (addr == OFS_STATUS_BITS)
         begin
            next_rdata = {13'h0000, bcr, me, busy};
         end
         else if (addr == OFS_DESC_CTRL)
         begin
            next_rdata = {13'h0000, desc};
         end
         else if (addr == OFS_MSG_INFO)
         begin
            next_rdata = {10'h000, info};
         end
         else if (addr == OFS_INT_STATUS)
         begin
            next_rdata = {12'h000, int_stat};
         end
         else if (addr == OFS_INT_ENABLE)
         begin
            next_rdata = {12'h000, int_en};
         end
         else if (addr == OFS_SHUTDOWN)
         begin
            next_rdata = {14'h0000, shut};
         end
         else if (addr == OFS_BIT_WORD)
         begin
            next_rdata = bit_word;
         end
         else
         begin
            next_rdata = 16'h0000;
         end
      end
      // Sticky events: a new event wins over a clear in the same cycle
      next_int_stat = (int_stat & ~(wr_hit ? wdata[NUM_INT-1:0] : 4'h0)) | int_set;
   end

   // State registers
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state <= MCH_IDLE;
         umc_inv <= 1'b0;
         desc <= 3'h0;
         info <= 6'h00;
         int_stat <= 4'h0;
         int_en <= 4'h0;
         me <= 1'b0;
         bcr <= 1'b0;
         busy <= 1'b0;
         bit_word <= BIT_WORD_RESET;
         shut <= 2'h0;
         status_send <= 1'b0;
         msg_write <= 1'b0;
         rdata <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         umc_inv <= next_umc_inv;
         desc <= next_desc;
         info <= next_info;
         int_stat <= next_int_stat;
         int_en <= next_int_en;
         me <= next_me;
         bcr <= next_bcr;
         busy <= next_busy;
         bit_word <= next_bit_word;
         shut <= next_shut;
         status_send <= next_status_send;
         msg_write <= next_msg_write;
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Level outputs straight from the registers
   assign status_me = me;
   assign status_bcr = bcr;
   assign status_busy = busy;
   assign flag_inhibit = bit_word[BIT_FLAG_INH];
   assign shutdown_a = shut[0];
   assign shutdown_b = shut[1];
   assign irq = |(int_stat & int_en);

   ////////////////////////////////////////////////////////////////////////////////
   ignored_quiet_a: assert property (@(posedge clock) disable iff (rst)
      cmd_valid && is_mc && ignored && !wr |=> !status_send && !msg_write
         && $stable(int_stat) && $stable(desc))
      else $error("ignored command changed state");

   rx_inform_a: assert property (@(posedge clock) disable iff (rst)
      rx_form && !cmd_illegal |=> !me && status_send == !$past(cmd_broadcast))
      else $error("in-form receive answer wrong");

   rx_desc_a: assert property (@(posedge clock) disable iff (rst)
      rx_form |=> desc[DESC_BUFFER_ACCESSED_FLAG] && desc[DESC_DPB] != $past(desc[DESC_DPB])
         && (info & INFO_ERR_MASK) == ($past(cmd_illegal) ? 6'h06 : 6'h00)
         && int_stat[INT_WORD_ACCESS])
      else $error("receive form descriptor or info wrong");

   rx_illegal_a: assert property (@(posedge clock) disable iff (rst)
      rx_form && cmd_illegal |=> me && info[INFO_ILLEGAL_COMMAND_INFO] && info[INFO_MESSAGE_ERROR_INFO]
         && int_stat[INT_ILLEGAL])
      else $error("illegal receive form not flagged");

   data_error_a: assert property (@(posedge clock) disable iff (rst)
      take && cmd_data_follows |=> me && !status_send && !desc[DESC_BROADCAST_FLAG]
         && info[INFO_WORD_COUNT_ERROR_INFO] == ($past(cmd_mode_code) == MC_OVERRIDE_FLAG)
         && info[INFO_GAP_ERROR_INFO] == ($past(cmd_mode_code) == MC_RESET_TERM))
      else $error("data word after mode code handled wrong");

   reset_tx_a: assert property (@(posedge clock) disable iff (rst)
      mc8_tx && !cmd_broadcast |=> status_send && !me && !desc[DESC_BUFFER_ACCESSED_FLAG]
         && (info & INFO_ERR_MASK) == 6'h00 ##1 !status_send)
      else $error("reset terminal answer wrong");

   status_clear_a: assert property (@(posedge clock) disable iff (rst)
      state == MCH_WAIT_TX && status_tx_done && !take && !wr |=> !me && !busy && !bcr)
      else $error("status bits not cleared after status");

   reset_effects_a: assert property (@(posedge clock) disable iff (rst)
      mc8_tx && !wr |=> bit_word == 16'h0000 && !shutdown_a && !shutdown_b
         && !flag_inhibit && umc_inv == $past(umc_inv))
      else $error("reset terminal effects missing");

   override_flag_a: assert property (@(posedge clock) disable iff (rst)
      mc7_tx && !wr |=> !flag_inhibit && bit_word[15:1] == $past(bit_word[15:1]))
      else $error("flag inhibit not overridden");
endmodule // mch_handler

// [sim/mch_bc_model.sv]
// Bus controller side model: answers each status request with a sent pulse
`timescale 1ns/1ns
module mch_bc_model
(
   input wire logic clock,
   input wire logic rst,
   input wire logic slow,
   input wire logic status_send,
   output logic status_tx_done
);
   logic [3:0] cnt;
   ////////////////////////////////////////////////////////////////////////////
   // A status word takes time on the wire; slow mode stretches it so that
   // anything cleared early by the block would show before the pulse
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cnt <= 4'h0;
         status_tx_done <= 1'b0;
      end
      else
      begin
         status_tx_done <= (cnt == 4'h1);
         if (status_send)
            cnt <= slow ? 4'hF : 4'h2;
         else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
      end
   end
endmodule // mch_bc_model

// [sim/tb.sv]
// Self-checking bench for the mode command 7/8 handler
`timescale 1ns/1ns
module tb;
   import mch_pkg::*;
   localparam logic Y = 1'b1;
   localparam logic N = 1'b0;
   logic clock = 1'b0, rst = 1'b1, slow = 1'b0, pingpong_select = 1'b0;
   logic cmd_valid = N, cmd_word_ok = N, cmd_tr = N, cmd_broadcast = N, cmd_bus_b = N;
   logic cmd_illegal = N, cmd_data_follows = N, wr = N, rd = N;
   logic [4:0] cmd_mode_code = 5'h00;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata;
   logic status_send, msg_write, status_me, status_bcr, status_busy, status_tx_done;
   logic flag_inhibit, shutdown_a, shutdown_b, irq;
   int err_count = 0;
   int n_tests = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Clock and the two parties
   always #5 clock = ~clock;
   mch_handler dut_u (.clock, .rst, .cmd_valid, .cmd_word_ok, .cmd_mode_code, .cmd_tr,
      .cmd_broadcast, .cmd_bus_b, .cmd_illegal, .cmd_data_follows, .status_tx_done, .addr,
      .wdata, .wr, .rd, .rdata, .status_send, .msg_write, .status_me, .status_bcr,
      .status_busy, .flag_inhibit, .shutdown_a, .shutdown_b, .irq);
   mch_bc_model bc_u (.clock, .rst, .slow, .status_send, .status_tx_done);
   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   function automatic logic [15:0] bit_at(input int p);
      return 16'h0001 << p;
   endfunction
   // Descriptor word; the ping-pong bit comes from the bench's own count
   function automatic logic [15:0] dv(input logic d, input logic b);
      return (16'(d) << DESC_BUFFER_ACCESSED_FLAG) | (16'(b) << DESC_BROADCAST_FLAG) | (16'(pingpong_select) << DESC_DPB);
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      wr <= Y;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= N;
   endtask
   // Read data appear in the cycle after the strobe and hold until the next read
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock);
      rd <= Y;
      addr <= a;
      @(posedge clock);
      rd <= N;
      #1 chk(rdata, e);
   endtask
   // One decoded command; p says whether the block must act on it
   task automatic send(input logic ok, input logic [4:0] m, input logic tr, bc, b, ill, df,
                       input logic snd, p);
      @(posedge clock);
      cmd_valid <= Y;
      cmd_word_ok <= ok;
      cmd_mode_code <= m;
      cmd_tr <= tr;
      cmd_broadcast <= bc;
      cmd_bus_b <= b;
      cmd_illegal <= ill;
      cmd_data_follows <= df;
      @(posedge clock);
      cmd_valid <= N;
      pingpong_select = pingpong_select ^ p;
      #1 chk({14'h0, status_send, msg_write}, {14'h0, snd, p});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic sc_ignore();
      reg_wr(OFS_INT_ENABLE, 16'h000F);
      reg_wr(OFS_SHUTDOWN, 16'h0003);
      reg_wr(OFS_BIT_WORD, 16'h0001);
      reg_wr(OFS_CONFIG, 16'h0001);
      send(N, MC_RESET_TERM, Y, N, N, N, N, N, N);
      send(Y, MC_RESET_TERM, N, N, N, N, N, N, N);
      send(Y, MC_OVERRIDE_FLAG, N, Y, N, Y, N, N, N);
      send(Y, 5'h06, Y, N, N, N, N, N, N);
      chk({12'h0, irq, status_me, shutdown_a, flag_inhibit}, 16'h0003);
      rchk(OFS_DESC_CTRL, 16'h0000);
      rchk(OFS_MSG_INFO, 16'h0000);
      rchk(OFS_INT_STATUS, 16'h0000);
      reg_wr(OFS_CONFIG, 16'h0000);
   endtask
   // Receive forms of both codes, legal and illegal, direct and broadcast
   task automatic sc_rx();
      logic bc, ill, b;
      for (int i = 0; i < 8; i++)
      begin
         bc = i[0];
         ill = i[1];
         b = i[0] ^ i[1];
         reg_wr(OFS_INT_CLEAR, 16'h000F);
         send(Y, i[2] ? MC_RESET_TERM : MC_OVERRIDE_FLAG, N, bc, b, ill, N, !bc, Y);
         chk({14'h0, status_me, status_bcr | !bc}, {14'h0, ill, Y});
         rchk(OFS_DESC_CTRL, dv(Y, bc));
         rchk(OFS_MSG_INFO, 16'(b) | (16'(ill) << INFO_MESSAGE_ERROR_INFO) | (16'(ill) << INFO_ILLEGAL_COMMAND_INFO));
         rchk(OFS_INT_STATUS, bit_at(INT_WORD_ACCESS) | (16'(bc) << INT_BROADCAST)
              | (16'(ill) << INT_ILLEGAL));
      end
   endtask
   // Data word after the command; broadcast must still leave the flag low
   task automatic sc_df();
      reg_wr(OFS_INT_CLEAR, 16'h000F);
      send(Y, MC_OVERRIDE_FLAG, Y, Y, N, N, Y, N, Y);
      chk({15'h0, status_me}, 16'h0001);
      rchk(OFS_DESC_CTRL, dv(Y, N));
      rchk(OFS_MSG_INFO, bit_at(INFO_MESSAGE_ERROR_INFO) | bit_at(INFO_WORD_COUNT_ERROR_INFO));
      send(Y, MC_RESET_TERM, Y, N, Y, N, Y, N, Y);
      rchk(OFS_DESC_CTRL, dv(Y, N));
      rchk(OFS_MSG_INFO, 16'h0001 | bit_at(INFO_MESSAGE_ERROR_INFO) | bit_at(INFO_GAP_ERROR_INFO));
      rchk(OFS_INT_STATUS, bit_at(INT_WORD_ACCESS) | bit_at(INT_MSG_ERROR));
   endtask
   // Reset-terminal with a slow transmitter: some clears wait for the status
   task automatic sc_mc8();
      int n;
      slow <= Y;
      reg_wr(OFS_SHUTDOWN, 16'h0003);
      reg_wr(OFS_BIT_WORD, 16'h00A5);
      reg_wr(OFS_STATUS_BITS, 16'h0001);
      reg_wr(OFS_CONFIG, 16'h0001);
      reg_wr(OFS_INT_CLEAR, 16'h000F);
      #1 chk({11'h0, status_me, status_busy, shutdown_a, shutdown_b, flag_inhibit},
             16'h001F);
      send(Y, MC_RESET_TERM, Y, N, Y, N, N, Y, Y);
      chk({10'h0, status_bcr, status_me, status_busy, shutdown_a, shutdown_b, flag_inhibit},
          16'h0028);
      n = 0;
      while (status_tx_done !== Y && n < 50)
      begin
         @(posedge clock);
         #1 n++;
      end
      @(posedge clock);
      #1 chk(16'(n >= 50), 16'h0000);
      chk({13'h0, status_me, status_busy, status_bcr}, 16'h0000);
      rchk(OFS_BIT_WORD, BIT_WORD_RESET);
      rchk(OFS_CONFIG, 16'h0001);
      rchk(OFS_INT_ENABLE, 16'h000F);
      rchk(OFS_DESC_CTRL, dv(N, N));
      rchk(OFS_MSG_INFO, 16'h0001);
      rchk(OFS_INT_STATUS, bit_at(INT_WORD_ACCESS));
      reg_wr(OFS_CONFIG, 16'h0000);
      slow <= N;
   endtask
   task automatic sc_mc7();
      reg_wr(OFS_BIT_WORD, 16'h0003);
      reg_wr(OFS_INT_CLEAR, 16'h000F);
      send(Y, MC_OVERRIDE_FLAG, Y, Y, N, N, N, N, Y);
      chk({13'h0, status_me, status_bcr, flag_inhibit}, 16'h0002);
      rchk(OFS_BIT_WORD, 16'h0002);
      rchk(OFS_DESC_CTRL, dv(N, Y));
      rchk(OFS_INT_STATUS, bit_at(INT_WORD_ACCESS) | bit_at(INT_BROADCAST));
   endtask
   // Interrupt mask and clear, unmapped read, software reset by the host
   task automatic sc_host();
      reg_wr(OFS_INT_ENABLE, bit_at(INT_MSG_ERROR));
      #1 chk({15'h0, irq}, 16'h0000);
      reg_wr(OFS_INT_ENABLE, bit_at(INT_BROADCAST));
      #1 chk({15'h0, irq}, 16'h0001);
      reg_wr(OFS_INT_CLEAR, bit_at(INT_BROADCAST));
      #1 chk({15'h0, irq}, 16'h0000);
      rchk(OFS_INT_STATUS, bit_at(INT_WORD_ACCESS));
      rchk(8'hFF, 16'h0000);
      reg_wr(OFS_BIT_WORD, 16'h0001);
      reg_wr(OFS_CONFIG, bit_at(CFG_SW_RESET));
      #1 chk({15'h0, flag_inhibit}, 16'h0000);
      rchk(OFS_CONFIG, 16'h0000);
   endtask
   // Master reset pulled by the host in mid-run; ping-pong must restart too
   task automatic sc_mr();
      reg_wr(OFS_BIT_WORD, 16'h0001);
      reg_wr(OFS_SHUTDOWN, 16'h0003);
      reg_wr(OFS_INT_ENABLE, 16'h000F);
      @(posedge clock);
      rst <= Y;
      repeat (2) @(posedge clock);
      rst <= N;
      pingpong_select = N;
      #1 chk({10'h0, irq, status_me, status_busy, status_bcr, shutdown_a, flag_inhibit},
             16'h0000);
      rchk(OFS_INT_ENABLE, 16'h0000);
      send(Y, MC_OVERRIDE_FLAG, Y, N, N, N, N, Y, Y);
      rchk(OFS_DESC_CTRL, dv(N, N));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Verdict, main sequence and watchdog
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clock);
      rst <= N;
      sc_ignore();
      sc_rx();
      sc_df();
      sc_mc8();
      sc_mc7();
      sc_host();
      sc_mr();
      tally_and_finish();
   end
   // The run needs well under 2000 cycles
   initial
   begin
      #200000;
      err_count++;
      tally_and_finish();
   end
endmodule // tb
